// File: hw/pwm_cfg.svh
// Offsets, field positions, reset values and timing figures of the PWM block
// Included by the package and the PWM module; definitions only
`ifndef PWM_CFG_SVH
`define PWM_CFG_SVH
`define CLK_NS        50
`define OFF_PIN_CFG   8'h00
`define OFF_STATUS    8'h04
`define OFF_MASK      8'h08
`define OFF_ACTIVE    8'h0C
`define OFF_CH0_CODE  8'h10
`define OFF_CH0_DUTY  8'h14
`define OFF_CH1_CODE  8'h18
`define OFF_CH1_DUTY  8'h1C
`define ST_ERR_LSB    0
`define ST_START_LSB  2
`define RST_WORD      32'h0000_0000
`define CODE_LAST     24
`define CODE_COARSE   20
`define DUTY_MAX_FINE 999
`define DUTY_MAX_CRS  990
`define DUTY_UNIT_CRS 10
`define RES_FINE      1000
`define RES_CRS       100
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2
`endif

// File: hw/pwm_pkg.sv
// Types shared by the PWM block: bus carriers and per-channel settings
// Assumes pwm_cfg.svh is on the include path
`include "pwm_cfg.svh"
package pwm_pkg;
  typedef struct packed {
    logic [7:0]  awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [7:0]  araddr;
    logic        arvalid;
    logic        rready;
  } axil_req_t;
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
  } axil_rsp_t;
  typedef struct packed {
    logic [15:0] code;
    logic [15:0] duty;
  } chan_set_t;
endpackage : pwm_pkg

// File: hw/pwm_out.sv
// Two-channel PWM output generator with an AXI4-Lite register port
// Assumes one 20 MHz clock; run pins are asynchronous and are synchronised here
//
// Chosen here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`include "pwm_cfg.svh"

// Behaviour
// - output duty follows programmed duty setting
// - code picks fixed period from table
// - fine codes take duty 0 to 999
// - coarse codes: duty 0-990, 10 units
// - out-of-range duty while running is clamped
// - out-of-range duty at start gives error
// - output runs only while run held
module pwm_out (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              nrst_i,
  // Register bus
  input  wire pwm_pkg::axil_req_t axi_req_i,
  output pwm_pkg::axil_rsp_t     axi_rsp_o,
  // Run condition pins, one per channel
  input  wire logic [1:0]        pwm_run_condition_i,
  // PWM pins and interrupt
  output logic                   pwm_pin_a_o,
  output logic                   pwm_pin_b_o,
  output logic                   irq_o
);
  import pwm_pkg::*;

  localparam int NCH = 2;

  // Period of each frequency code in ns
  function automatic int period_ns(input int k);
    case (k)
      0:       period_ns = 666670000;
      1:       period_ns = 502510000;
      2:       period_ns = 245700000;
      3:       period_ns = 163930000;
      4:       period_ns = 122850000;
      5:       period_ns = 102350000;
      6:       period_ns = 51200000;
      7:       period_ns = 20480000;
      8:       period_ns = 10240000;
      9:       period_ns = 4960000;
      10:      period_ns = 2480000;
      11:      period_ns = 2000000;
      12:      period_ns = 1440000;
      13:      period_ns = 960000;
      14:      period_ns = 800000;
      15:      period_ns = 640000;
      16:      period_ns = 480000;
      17:      period_ns = 320000;
      18:      period_ns = 160000;
      19:      period_ns = 80000;
      20:      period_ns = 60000;
      21:      period_ns = 50000;
      22:      period_ns = 40000;
      23:      period_ns = 30000;
      default: period_ns = 20000;
    endcase
  endfunction : period_ns

  logic [15:0] step_lut [0:`CODE_LAST];

  genvar g;
  generate
    for (g = 0; g <= `CODE_LAST; g++) begin : g_lut
      localparam int RES = (g < `CODE_COARSE) ? `RES_FINE : `RES_CRS;
      localparam int DIV = `CLK_NS * RES;
      assign step_lut[g] = 16'((period_ns(g) + DIV / 2) / DIV);
    end
  endgenerate

  // Registers
  logic [1:0]  pin_cfg_r;
  logic [3:0]  status_r;
  logic [3:0]  mask_r;
  chan_set_t   set_r [NCH];
  logic [1:0]  run_r;
  logic [1:0]  err_ev;
  logic [1:0]  start_ev;
  logic [1:0]  pin_out;

  // Write path: address and data are taken together
  logic        wr_go;
  logic [31:0] wmask;
  logic [7:0]  waddr;
  logic        bvalid_r;
  logic [1:0]  bresp_r;

  assign wr_go = axi_req_i.awvalid && axi_req_i.wvalid && !bvalid_r;
  assign waddr = axi_req_i.awaddr;
  assign wmask = {{8{axi_req_i.wstrb[3]}}, {8{axi_req_i.wstrb[2]}},
                  {8{axi_req_i.wstrb[1]}}, {8{axi_req_i.wstrb[0]}}};

  // Write data merged byte by byte into each register's current value
  logic [31:0] pin_cfg_m, mask_m, code0_m, duty0_m, code1_m, duty1_m;
  assign pin_cfg_m = ({30'h0, pin_cfg_r} & ~wmask) | (axi_req_i.wdata & wmask);
  assign mask_m    = ({28'h0, mask_r} & ~wmask) | (axi_req_i.wdata & wmask);
  assign code0_m   = ({16'h0, set_r[0].code} & ~wmask) | (axi_req_i.wdata & wmask);
  assign duty0_m   = ({16'h0, set_r[0].duty} & ~wmask) | (axi_req_i.wdata & wmask);
  assign code1_m   = ({16'h0, set_r[1].code} & ~wmask) | (axi_req_i.wdata & wmask);
  assign duty1_m   = ({16'h0, set_r[1].duty} & ~wmask) | (axi_req_i.wdata & wmask);

  logic wr_hit;
  always_comb begin
    case (waddr)
      `OFF_PIN_CFG, `OFF_STATUS, `OFF_MASK, `OFF_ACTIVE,
      `OFF_CH0_CODE, `OFF_CH0_DUTY, `OFF_CH1_CODE, `OFF_CH1_DUTY: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bvalid_r <= 1'b0;
      bresp_r  <= `RESP_OKAY;
    end else if (wr_go) begin
      bvalid_r <= 1'b1;
      bresp_r  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (axi_req_i.bready) begin
      bvalid_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin_cfg_r <= 2'h0;
      mask_r    <= 4'h0;
      for (int c = 0; c < NCH; c++) begin
        set_r[c] <= `RST_WORD;
      end
    end else if (wr_go) begin
      case (waddr)
        `OFF_PIN_CFG:  pin_cfg_r        <= pin_cfg_m[1:0];
        `OFF_MASK:     mask_r           <= mask_m[3:0];
        `OFF_CH0_CODE: set_r[0].code    <= code0_m[15:0];
        `OFF_CH0_DUTY: set_r[0].duty    <= duty0_m[15:0];
        `OFF_CH1_CODE: set_r[1].code    <= code1_m[15:0];
        `OFF_CH1_DUTY: set_r[1].duty    <= duty1_m[15:0];
        default: ;
      endcase
    end
  end

  // Sticky events; a new event wins over a write-one clear
  logic [3:0] st_set;
  logic [3:0] st_clr;
  assign st_set = {start_ev, err_ev};
  assign st_clr = (wr_go && waddr == `OFF_STATUS) ?
                  (axi_req_i.wdata[3:0] & wmask[3:0]) : 4'h0;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      status_r <= 4'h0;
    end else begin
      status_r <= (status_r & ~st_clr) | st_set;
    end
  end

  assign irq_o = |(status_r & mask_r);

  // Read path
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;
  logic        rd_go;
  logic [31:0] rd_word;
  logic        rd_hit;

  assign rd_go = axi_req_i.arvalid && !rvalid_r;

  always_comb begin
    rd_hit  = 1'b1;
    rd_word = 32'h0;
    case (axi_req_i.araddr)
      `OFF_PIN_CFG:  rd_word = {30'h0, pin_cfg_r};
      `OFF_STATUS:   rd_word = {28'h0, status_r};
      `OFF_MASK:     rd_word = {28'h0, mask_r};
      `OFF_ACTIVE:   rd_word = {28'h0, pin_out, run_r};
      `OFF_CH0_CODE: rd_word = {16'h0, set_r[0].code};
      `OFF_CH0_DUTY: rd_word = {16'h0, set_r[0].duty};
      `OFF_CH1_CODE: rd_word = {16'h0, set_r[1].code};
      `OFF_CH1_DUTY: rd_word = {16'h0, set_r[1].duty};
      default:       rd_hit  = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rvalid_r <= 1'b0;
      rdata_r  <= `RST_WORD;
      rresp_r  <= `RESP_OKAY;
    end else if (rd_go) begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_word;
      rresp_r  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (axi_req_i.rready) begin
      rvalid_r <= 1'b0;
    end
  end

  always_comb begin
    axi_rsp_o.awready = wr_go;
    axi_rsp_o.wready  = wr_go;
    axi_rsp_o.bvalid  = bvalid_r;
    axi_rsp_o.bresp   = bresp_r;
    axi_rsp_o.arready = rd_go;
    axi_rsp_o.rvalid  = rvalid_r;
    axi_rsp_o.rdata   = rdata_r;
    axi_rsp_o.rresp   = rresp_r;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  // Channel engines
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      logic        sync1_r, sync2_r, prev_r;
      logic        out_r;
      logic [4:0]  code_r;
      logic [15:0] pre_r;
      logic [9:0]  pos_r;
      logic        coarse, bad, start;
      logic [9:0]  lim, dsteps, res_last;
      logic [15:0] dcl;
      logic [15:0] step;

      always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          sync1_r <= 1'b0;
          sync2_r <= 1'b0;
          prev_r  <= 1'b0;
        end else begin
          sync1_r <= pwm_run_condition_i[g];
          sync2_r <= sync1_r;
          prev_r  <= sync2_r;
        end
      end

      assign start = pin_cfg_r[g] && sync2_r && !prev_r && !run_r[g];
      assign bad   = set_r[g].code > `CODE_LAST ||
                     set_r[g].duty > ((set_r[g].code >= `CODE_COARSE) ?
                                      `DUTY_MAX_CRS : `DUTY_MAX_FINE);
      assign coarse = code_r >= 5'(`CODE_COARSE);
      assign lim    = coarse ? 10'(`DUTY_MAX_CRS) : 10'(`DUTY_MAX_FINE);
      assign dcl    = (set_r[g].duty > {6'h0, lim}) ? {6'h0, lim} : set_r[g].duty;
      assign dsteps = coarse ? 10'(dcl / `DUTY_UNIT_CRS) : dcl[9:0];
      assign res_last = coarse ? 10'(`RES_CRS - 1) : 10'(`RES_FINE - 1);
      assign step   = step_lut[code_r];
      assign err_ev[g]   = start && bad;
      assign start_ev[g] = start && !bad;

      always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          run_r[g] <= 1'b0;
          code_r   <= 5'h0;
          pre_r    <= 16'h0;
          pos_r    <= 10'h0;
        end else if (!run_r[g]) begin
          if (start && !bad) begin
            run_r[g] <= 1'b1;
            code_r   <= set_r[g].code[4:0];
            pre_r    <= 16'h0;
            pos_r    <= 10'h0;
          end
        end else if (!sync2_r || !pin_cfg_r[g]) begin
          run_r[g] <= 1'b0;
        end else if (pre_r == step - 16'h1) begin
          pre_r <= 16'h0;
          pos_r <= (pos_r == res_last) ? 10'h0 : pos_r + 10'h1;
        end else begin
          pre_r <= pre_r + 16'h1;
        end
      end

      always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          out_r <= 1'b0;
        end else begin
          out_r <= run_r[g] && sync2_r && pin_cfg_r[g] && pos_r < dsteps;
        end
      end
      assign pin_out[g] = out_r;

      sequence s_bad_start;
        start && bad;
      endsequence
      sequence s_err_seen;
        !run_r[g] && status_r[`ST_ERR_LSB + g];
      endsequence

      a_duty_high: assert property (run_r[g] && sync2_r && pin_cfg_r[g]
        && pos_r < dsteps |=> out_r)
        else $error("pwm output low inside duty");
      a_duty_low: assert property (run_r[g] && pos_r >= dsteps |=> !out_r)
        else $error("pwm output high beyond duty");
      a_period_wrap: assert property (run_r[g] && sync2_r && pin_cfg_r[g]
        && pre_r == step - 16'h1 && pos_r == res_last |=> pos_r == 10'h0)
        else $error("pwm period did not wrap");
      a_fine_range: assert property (run_r[g] && !coarse |-> dsteps <= 10'h3E7)
        else $error("fine duty above 999");
      a_coarse_units: assert property (run_r[g] && coarse |-> dsteps <= 10'h063)
        else $error("coarse duty above 99 units");
      a_clamp_run: assert property (run_r[g] && set_r[g].duty > {6'h0, lim}
        && sync2_r && pin_cfg_r[g] |=> run_r[g])
        else $error("running channel stopped on bad duty");
      a_start_error: assert property (s_bad_start |=> s_err_seen ##1 !run_r[g])
        else $error("bad duty start not refused");
      a_stop_drop: assert property (run_r[g] && !sync2_r |=> !run_r[g] ##1 !out_r)
        else $error("pwm kept running after run drop");
    end
  endgenerate

  assign pwm_pin_a_o = pin_out[0];
  assign pwm_pin_b_o = pin_out[1];

endmodule : pwm_out

// File: verif/pwm_out_tb.sv
// Self-checking bench for the two-channel PWM block
// Assumes pwm_cfg.svh on the include path and the 20 MHz clock of the design
`timescale 1ns/1ps
`include "pwm_cfg.svh"
module pwm_out_tb;
  import pwm_pkg::*;
  logic       clk_i;
  logic       nrst_i;
  axil_req_t  req;
  axil_rsp_t  rsp;
  logic [1:0] run;
  logic       pin_a;
  logic       pin_b;
  logic       irq;
  int         n_fail;
  int         n_tests;
  int         cycles;

  pwm_out i_dut (
    .clk_i              (clk_i),
    .nrst_i             (nrst_i),
    .axi_req_i          (req),
    .axi_rsp_o          (rsp),
    .pwm_run_condition_i(run),
    .pwm_pin_a_o        (pin_a),
    .pwm_pin_b_o        (pin_b),
    .irq_o              (irq)
  );

  always #25 clk_i = ~clk_i;

  // Cuts a hang short
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 40000) begin
      n_fail++;
      end_of_test();
    end
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check

  task automatic end_of_test;
    $display("checks %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    req.awaddr  <= a;
    req.wdata   <= d;
    req.wstrb   <= 4'hF;
    req.awvalid <= 1'b1;
    req.wvalid  <= 1'b1;
    req.bready  <= 1'b1;
    do @(posedge clk_i); while (rsp.awready !== 1'b1 || rsp.wready !== 1'b1);
    req.awvalid <= 1'b0;
    req.wvalid  <= 1'b0;
    do @(posedge clk_i); while (rsp.bvalid !== 1'b1);
    req.bready <= 1'b0;
    check("bresp", 32'(rsp.bresp), 32'(er));
    // Spacer edge: a following call must not re-raise bready in this step
    @(posedge clk_i);
  endtask : wr

  task automatic rd(input string n, input logic [7:0] a, input logic [31:0] ed,
                    input logic [1:0] er);
    req.araddr  <= a;
    req.arvalid <= 1'b1;
    req.rready  <= 1'b1;
    do @(posedge clk_i); while (rsp.arready !== 1'b1);
    req.arvalid <= 1'b0;
    do @(posedge clk_i); while (rsp.rvalid !== 1'b1);
    req.rready <= 1'b0;
    check(n, rsp.rdata, ed);
    check("rresp", 32'(rsp.rresp), 32'(er));
    // Spacer edge: a following call must not re-raise rready in this step
    @(posedge clk_i);
  endtask : rd

  // Counts high cycles of one channel's pin over n cycles
  task automatic meas(input string nm, input int ch, input int n, input int exp);
    int hi;
    hi = 0;
    repeat (n) begin
      @(posedge clk_i);
      if ((ch ? pin_b : pin_a) === 1'b1) hi++;
    end
    check(nm, 32'(hi), 32'(exp));
  endtask : meas

  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask : idle

  task automatic t_reset;
    rd("status", `OFF_STATUS, 32'h0, `RESP_OKAY);
    rd("mask", `OFF_MASK, 32'h0, `RESP_OKAY);
    rd("pin_cfg", `OFF_PIN_CFG, 32'h0, `RESP_OKAY);
    rd("unmapped", 8'h40, 32'h0, `RESP_SLVERR);
    wr(8'h40, 32'h1, `RESP_SLVERR);
    run <= 2'b11;
    meas("pin idle", 0, 50, 0);
    meas("pin b idle", 1, 50, 0);
    rd("no start", `OFF_STATUS, 32'h0, `RESP_OKAY);
    run <= 2'b00;
  endtask : t_reset

  // Bad duty on ch0 and bad code on ch1 at start: error on both, no output on ch0 pin
  task automatic t_err;
    wr(`OFF_PIN_CFG, 32'h3, `RESP_OKAY);
    wr(`OFF_MASK, 32'h1, `RESP_OKAY);
    wr(`OFF_CH0_CODE, 32'd6, `RESP_OKAY);
    wr(`OFF_CH0_DUTY, 32'd1000, `RESP_OKAY);
    wr(`OFF_CH1_CODE, 32'd25, `RESP_OKAY);
    wr(`OFF_CH1_DUTY, 32'd0, `RESP_OKAY);
    run <= 2'b11;
    idle(10);
    rd("status err", `OFF_STATUS, 32'h3, `RESP_OKAY);
    check("irq set", 32'(irq), 32'h1);
    meas("pin err", 0, 100, 0);
    run <= 2'b00;
    wr(`OFF_STATUS, 32'h3, `RESP_OKAY);
    rd("status clr", `OFF_STATUS, 32'h0, `RESP_OKAY);
    check("irq clr", 32'(irq), 32'h0);
  endtask : t_err

  // Code 19: 2000-cycle period, 2 cycles per duty step
  task automatic t_fine;
    wr(`OFF_CH0_CODE, 32'd19, `RESP_OKAY);
    wr(`OFF_CH0_DUTY, 32'd999, `RESP_OKAY);
    run <= 2'b01;
    idle(10);
    rd("start ch0", `OFF_STATUS, 32'h4, `RESP_OKAY);
    check("irq masked", 32'(irq), 32'h0);
    meas("duty 999", 0, 2000, 1998);
    wr(`OFF_CH0_DUTY, 32'd500, `RESP_OKAY);
    idle(2000);
    meas("duty 500", 0, 2000, 1000);
    wr(`OFF_CH0_DUTY, 32'd1500, `RESP_OKAY);
    idle(2000);
    meas("duty clamp", 0, 2000, 1998);
    rd("no err", `OFF_STATUS, 32'h4, `RESP_OKAY);
    wr(`OFF_CH0_DUTY, 32'd0, `RESP_OKAY);
    wr(`OFF_ACTIVE, 32'hF, `RESP_OKAY);
    rd("active", `OFF_ACTIVE, 32'h1, `RESP_OKAY);
    meas("duty 0", 0, 2000, 0);
    run <= 2'b00;
    idle(10);
    meas("stopped", 0, 2000, 0);
    rd("inactive", `OFF_ACTIVE, 32'h0, `RESP_OKAY);
    wr(`OFF_STATUS, 32'h4, `RESP_OKAY);
  endtask : t_fine

  // Code 24: 400-cycle period, 4 cycles per step, duty in tens
  task automatic t_coarse;
    wr(`OFF_CH1_CODE, 32'd24, `RESP_OKAY);
    wr(`OFF_CH1_DUTY, 32'd555, `RESP_OKAY);
    run <= 2'b10;
    idle(10);
    rd("start ch1", `OFF_STATUS, 32'h8, `RESP_OKAY);
    meas("duty 555", 1, 400, 220);
    wr(`OFF_CH1_DUTY, 32'd990, `RESP_OKAY);
    idle(400);
    meas("duty 990", 1, 400, 396);
    wr(`OFF_CH1_DUTY, 32'd2000, `RESP_OKAY);
    idle(400);
    meas("coarse clamp", 1, 400, 396);
    run <= 2'b00;
    idle(10);
    meas("ch1 stopped", 1, 400, 0);
  endtask : t_coarse

  initial begin
    clk_i  = 1'b0;
    nrst_i = 1'b0;
    req    = '0;
    run    = 2'b00;
    n_fail = 0;
    n_tests = 0;
    cycles = 0;
    idle(3);
    nrst_i <= 1'b1;
    t_reset();
    t_err();
    t_fine();
    t_coarse();
    end_of_test();
  end
endmodule : pwm_out_tb
